//--- hw/mmsio_pkg.sv
// constants, field positions and state codes of the multimode serial unit
// assumes a 200 MHz reference clock and an external shift clock on a port of its own
package mmsio_pkg;

  // ************************************************************
  // control register layout
  // ************************************************************
  localparam int          CTRL_W        = 8;
  localparam int          MODE_HI_BIT   = 7;
  localparam int          MODE_LO_BIT   = 6;
  localparam int          RUN_BIT       = 5;
  localparam int          RECV_BIT      = 4;
  localparam int          DIR_BIT       = 3;
  localparam int          OVR_BIT       = 2;
  localparam int          END_BIT       = 1;
  localparam int          IE_BIT        = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // ************************************************************
  // shift buffer and frame positions
  // ************************************************************
  localparam int          DATA_W        = 8;
  localparam int          SBUF_W        = 9;
  localparam int          STOP_BIT      = 8;
  localparam logic [3:0]  POS_START     = 4'h0;
  localparam logic [3:0]  POS_FIRST     = 4'h1;
  localparam logic [3:0]  POS_LAST      = 4'h8;
  localparam logic [3:0]  POS_ACK       = 4'h9;

  // ************************************************************
  // modes and timing
  // ************************************************************
  localparam logic [1:0]  MODE_SYNC     = 2'h0;
  localparam logic [1:0]  MODE_ASYNC    = 2'h1;
  localparam logic [1:0]  MODE_MASTER   = 2'h2;
  localparam logic [1:0]  MODE_SLAVE    = 2'h3;
  localparam int          DIV_W         = 8;
  localparam int          HALF_W        = 11;
  localparam int          ASYNC_SHIFT   = 2;   // async bit is four clocked bits long
  localparam int          RX_DEPTH      = 2;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_START = 7'h02,
    ST_LOW   = 7'h04,
    ST_HIGH  = 7'h08,
    ST_EXT   = 7'h10,
    ST_SLAVE = 7'h20,
    ST_HOLD  = 7'h40
  } mmsio_state_t;

endpackage

//--- hw/mmsio_sync.sv
// two flip-flop level synchroniser, one bit per lane
// assumes d is asynchronous to clk and each lane is crossed on its own
`timescale 1ns/1ps
module mmsio_sync import mmsio_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } mmsio_sync_t;

  mmsio_sync_t s;
  mmsio_sync_t next_s;

  if (W < 1) begin : g_bad_width
    $error("mmsio_sync: width must be at least one");
  end

  // first stage feeds only the second stage
  always_comb begin
    next_s        = s;
    next_s.meta   = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stable;

endmodule

//--- hw/mmsio_buf.sv
// small word buffer with valid/ready on both sides
// assumes both sides run on clk; depth is a power of two
`timescale 1ns/1ps
module mmsio_buf import mmsio_pkg::*; #(
  parameter int W     = SBUF_W,
  parameter int DEPTH = RX_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr;
    logic [PW-1:0]           rd;
    logic [CW-1:0]           cnt;
  } mmsio_buf_t;

  mmsio_buf_t s;
  mmsio_buf_t next_s;
  logic       push;
  logic       pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("mmsio_buf: depth must be a power of two, at least two");
  end

  // honest full and empty straight from the count
  assign in_ready  = (s.cnt != FULL);
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = s.wr + PW'(1);
    end
    if (pop) begin
      next_s.rd = s.rd + PW'(1);
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + CW'(1);
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

//--- hw/mmsio_serial_unit.sv
// multimode serial unit: clocked, async frame and two-wire bus master/slave
// assumes pins pass through the synchroniser here; link_clk is the external
// shift clock of mode 0 and may stand still between transfers
//
// Operation
// - bus lost on high-out/low-line, stop clocking
// - line bits always captured, even when sending
// - buffer read copies stop level to status
// - async mode starts frame on line fall
// - mode bits 00 clocked, 01 async
// - mode bits 10 master, 11 slave
// - one 8-bit control register with flags
`timescale 1ns/1ps
module mmsio_serial_unit import mmsio_pkg::*; (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              link_clk,
  input  wire logic              ctrl_wr,
  input  wire logic [CTRL_W-1:0] ctrl_wdata,
  output logic      [CTRL_W-1:0] serial_control_reg,
  input  wire logic              sbuf_wr,
  input  wire logic [SBUF_W-1:0] sbuf_wdata,
  input  wire logic              sbuf_rd,
  output logic      [SBUF_W-1:0] shift_buffer,
  output logic                   processor_status_word_b1,
  input  wire logic [DIV_W-1:0]  baud_divider,
  input  wire logic              ext_clock_select,
  input  wire logic              dio_tx_route,
  input  wire logic              shift_clock_pin_in,
  output logic                   shift_clock_pin_out,
  output logic                   shift_clock_pin_oe_n,
  input  wire logic              data_io_pin_in,
  output logic                   data_io_pin_out,
  output logic                   data_io_pin_oe_n,
  output logic                   data_output_pin,
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output logic      [SBUF_W-1:0] rx_data
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [2:0] bit_idx(input logic [3:0] pos, input logic msb_first);
    logic [2:0] k;
    k = pos[2:0] - 3'h1;
    return msb_first ? ~k : k;
  endfunction

  // level the unit drives for a frame position
  function automatic logic out_value(input logic [3:0] pos, input logic [1:0] mode,
                                     input logic recv, input logic dir,
                                     input logic [7:0] data, input logic b8);
    logic v;
    v = 1'b1;
    if (pos == POS_START) begin
      v = (mode == MODE_ASYNC) ? recv : 1'b1;
    end else if (pos <= POS_LAST) begin
      v = recv ? 1'b1 : data[bit_idx(pos, dir)];
    end else if (recv && mode == MODE_MASTER) begin
      v = b8;
    end else if (recv && mode == MODE_SLAVE) begin
      v = 1'b0;
    end
    return v;
  endfunction

  function automatic logic [HALF_W-1:0] half_period(input logic [DIV_W-1:0] div,
                                                    input logic [1:0] mode);
    logic [HALF_W-1:0] h;
    h = HALF_W'(div);
    if (mode == MODE_ASYNC) begin
      h = ((HALF_W'(div) + HALF_W'(1)) << ASYNC_SHIFT) - HALF_W'(1);
    end
    return h;
  endfunction

  // ************************************************************
  // link domain: external shift clock of mode 0
  // ************************************************************
  logic lk_rst_n;
  logic lk_rise_tgl;
  logic lk_bit;
  logic lk_fall_tgl;

  // reset is brought into the link domain before use
  mmsio_sync #(.W(1)) u_lk_rst (
    .clk   (link_clk),
    .rst_n (1'b1),
    .d     (rst_n),
    .q     (lk_rst_n)
  );

  // line level caught on the rising edge; held a whole link period
  always_ff @(posedge link_clk) begin
    if (!lk_rst_n) begin
      lk_rise_tgl <= 1'b0;
      lk_bit      <= 1'b0;
    end else begin
      lk_rise_tgl <= ~lk_rise_tgl;
      lk_bit      <= data_io_pin_in;
    end
  end

  always_ff @(negedge link_clk) begin
    if (!lk_rst_n) begin
      lk_fall_tgl <= 1'b0;
    end else begin
      lk_fall_tgl <= ~lk_fall_tgl;
    end
  end

  // ************************************************************
  // reference domain state
  // ************************************************************
  typedef struct packed {
    mmsio_state_t        state;
    logic [CTRL_W-1:0]   ctrl;
    logic [SBUF_W-1:0]   sbuf;
    logic [DATA_W-1:0]   shf;
    logic [3:0]          pos;
    logic [HALF_W-1:0]   tmr;
    logic                dout;
    logic                clk_out;
    logic                line_p;
    logic                scl_p;
    logic                rise_p;
    logic                fall_p;
    logic                psw1;
    logic                fin_req;
    logic [SBUF_W-1:0]   push_data;
  } mmsio_regs_t;

  mmsio_regs_t       s;
  mmsio_regs_t       n;
  logic              line_s;
  logic              scl_s;
  logic              rise_s;
  logic              fall_s;
  logic              buf_in_ready;
  logic [CTRL_W-1:0] cur;
  logic [1:0]        md;
  logic [1:0]        cmd;
  logic              recv;
  logic              dir;
  logic              bus_mode;
  logic              line_fall;
  logic              start_ev;
  logic              stop_ev;
  logic              scl_rise;
  logic              scl_fall;
  logic              rise_ev;
  logic              fall_ev;
  logic              run_start;
  logic [HALF_W-1:0] half;
  logic              end_set;
  logic              ovr_set;
  logic              run_clr;
  logic              run_set;

  // pins and link toggles all pass two flops before use
  mmsio_sync #(.W(4)) u_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     ({data_io_pin_in, shift_clock_pin_in, lk_rise_tgl, lk_fall_tgl}),
    .q     ({line_s, scl_s, rise_s, fall_s})
  );

  // received words wait here; a word waiting on a full buffer holds off the next transfer, except one begun by a bus start in slave mode
  mmsio_buf #(.W(SBUF_W), .DEPTH(RX_DEPTH)) u_rxbuf (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (s.fin_req),
    .in_ready  (buf_in_ready),
    .in_data   (s.push_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // ************************************************************
  // decode and events
  // ************************************************************
  // mode decode
  assign md        = s.ctrl[MODE_HI_BIT:MODE_LO_BIT];
  assign cur       = ctrl_wr ? ctrl_wdata : s.ctrl;
  assign cmd       = cur[MODE_HI_BIT:MODE_LO_BIT];
  assign recv      = cur[RECV_BIT];
  assign dir       = cur[DIR_BIT];
  assign bus_mode  = md[1];
  assign half      = half_period(baud_divider, cmd);
  assign line_fall = s.line_p && !line_s;
  assign scl_rise  = scl_s && !s.scl_p;
  assign scl_fall  = !scl_s && s.scl_p;
  assign start_ev  = scl_s && s.scl_p && line_fall;
  assign stop_ev   = scl_s && s.scl_p && !s.line_p && line_s;
  // lk_bit is stable for a whole link period once the toggle is seen
  assign rise_ev   = rise_s != s.rise_p;
  assign fall_ev   = fall_s != s.fall_p;
  // run flag rising starts a transfer in every mode but slave
  assign run_start = ctrl_wr && ctrl_wdata[RUN_BIT] && !s.ctrl[RUN_BIT] && !s.fin_req;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    n        = s;
    end_set  = 1'b0;
    ovr_set  = 1'b0;
    run_clr  = 1'b0;
    run_set  = 1'b0;
    n.line_p = line_s;
    n.scl_p  = scl_s;
    n.rise_p = rise_s;
    n.fall_p = fall_s;
    // stop level copied to status on read
    if (sbuf_rd) begin
      n.psw1 = s.sbuf[STOP_BIT];
    end
    if (sbuf_wr) begin
      n.sbuf = sbuf_wdata;
    end
    // end flag rises once the word is in the buffer, or on a bus stop condition
    if (s.fin_req && buf_in_ready) begin
      n.fin_req = 1'b0;
      end_set   = 1'b1;
    end
    case (s.state)
      ST_IDLE: begin
        n.clk_out = 1'b1;
        n.dout    = 1'b1;
        // shifter loaded at start of operation
        if (run_start && cmd != MODE_SLAVE) begin
          n.shf = s.sbuf[DATA_W-1:0];
          n.pos = (cmd == MODE_ASYNC) ? POS_START : POS_FIRST;
          n.tmr = half;
          if (cmd == MODE_MASTER) begin
            n.state = ST_START;
            n.dout  = 1'b0;
          end else begin
            n.state   = (cmd == MODE_SYNC && ext_clock_select) ? ST_EXT : ST_LOW;
            n.clk_out = (cmd == MODE_SYNC && ext_clock_select);
            n.dout    = out_value(n.pos, cmd, recv, dir, n.shf, s.sbuf[STOP_BIT]);
          end
        // async frame started by a falling line
        end else if (md == MODE_ASYNC && line_fall && !s.fin_req) begin
          run_set = 1'b1;
          n.shf   = s.sbuf[DATA_W-1:0];
          n.pos   = POS_START;
          n.tmr   = half;
          n.state = ST_LOW;
          n.dout  = out_value(POS_START, md, recv, dir, n.shf, s.sbuf[STOP_BIT]);
        end
      end
      ST_START: begin
        if (s.tmr != '0) begin
          n.tmr = s.tmr - HALF_W'(1);
        end else begin
          n.state   = ST_LOW;
          n.clk_out = 1'b0;
          n.tmr     = half;
          n.dout    = out_value(s.pos, md, recv, dir, s.shf, s.sbuf[STOP_BIT]);
        end
      end
      ST_LOW: begin
        if (s.tmr != '0) begin
          n.tmr = s.tmr - HALF_W'(1);
        end else begin
          n.state   = ST_HIGH;
          n.clk_out = 1'b1;
          n.tmr     = half;
          if (s.pos >= POS_FIRST && s.pos <= POS_LAST) begin
            n.shf[bit_idx(s.pos, dir)] = line_s;
            // lost bus: drop run, release clock
            if (md == MODE_MASTER && s.dout && !line_s) begin
              run_clr   = 1'b1;
              n.state   = ST_IDLE;
              n.dout    = 1'b1;
            end else if (s.pos == POS_LAST) begin
              // shifter written back on eighth bit
              n.sbuf[DATA_W-1:0] = n.shf;
              if (md == MODE_SYNC) begin
                n.fin_req   = 1'b1;
                n.push_data = {s.sbuf[STOP_BIT], n.shf};
                run_clr     = 1'b1;
                n.state     = ST_IDLE;
              end
            end
          end else if (s.pos == POS_ACK) begin
            n.sbuf[STOP_BIT] = line_s;
            if (md == MODE_MASTER) begin
              n.fin_req   = 1'b1;
              n.push_data = {line_s, s.sbuf[DATA_W-1:0]};
            end
          end
        end
      end
      ST_HIGH: begin
        if (s.tmr != '0) begin
          n.tmr = s.tmr - HALF_W'(1);
        end else if (md == MODE_ASYNC && s.pos == POS_ACK) begin
          n.fin_req   = 1'b1;
          n.push_data = s.sbuf;
          run_clr     = 1'b1;
          n.state     = ST_IDLE;
        end else if (md == MODE_MASTER && s.pos == POS_ACK) begin
          n.state   = ST_HOLD;
          n.clk_out = 1'b0;
          n.dout    = 1'b1;
        end else begin
          n.pos     = s.pos + 4'h1;
          n.state   = ST_LOW;
          n.clk_out = 1'b0;
          n.tmr     = half;
          n.dout    = out_value(n.pos, md, recv, dir, s.shf, s.sbuf[STOP_BIT]);
        end
      end
      ST_EXT: begin
        if (!s.ctrl[RUN_BIT]) begin
          n.state = ST_IDLE;
        end else if (rise_ev) begin
          n.shf[bit_idx(s.pos, dir)] = lk_bit;
          if (s.pos == POS_LAST) begin
            n.sbuf[DATA_W-1:0] = n.shf;
            n.fin_req          = 1'b1;
            n.push_data        = {s.sbuf[STOP_BIT], n.shf};
            run_clr            = 1'b1;
            n.state            = ST_IDLE;
          end else begin
            n.pos  = s.pos + 4'h1;
            n.dout = out_value(n.pos, md, recv, dir, n.shf, s.sbuf[STOP_BIT]);
          end
        end
      end
      ST_SLAVE: begin
        if (scl_rise && s.pos <= POS_LAST) begin
          n.shf[bit_idx(s.pos, dir)] = line_s;
          if (s.pos == POS_LAST) begin
            n.sbuf[DATA_W-1:0] = n.shf;
          end
        end else if (scl_rise) begin
          n.sbuf[STOP_BIT] = line_s;
          // no acknowledge from master ends a slave send
          if (!recv && line_s) begin
            run_clr = 1'b1;
            n.state = ST_IDLE;
            n.dout  = 1'b1;
          end
        end else if (scl_fall && s.pos == POS_LAST) begin
          // stretch the clock until software has cleared end
          n.state     = ST_HOLD;
          n.clk_out   = 1'b0;
          n.pos       = POS_ACK;
          n.tmr       = HALF_W'(baud_divider);
          n.fin_req   = 1'b1;
          n.push_data = {s.sbuf[STOP_BIT], s.shf};
          n.dout      = out_value(POS_ACK, md, recv, dir, s.shf, s.sbuf[STOP_BIT]);
        end else if (scl_fall && s.pos == POS_ACK) begin
          n.pos  = POS_FIRST;
          n.shf  = s.sbuf[DATA_W-1:0];
          n.dout = out_value(POS_FIRST, md, recv, dir, n.shf, s.sbuf[STOP_BIT]);
        end else if (scl_fall) begin
          n.pos  = s.pos + 4'h1;
          n.dout = out_value(n.pos, md, recv, dir, s.shf, s.sbuf[STOP_BIT]);
        end
      end
      ST_HOLD: begin
        if (!s.ctrl[RUN_BIT]) begin
          n.state   = ST_IDLE;
          n.clk_out = 1'b1;
          n.dout    = 1'b1;
        end else if (!s.ctrl[END_BIT] && !s.fin_req) begin
          if (md == MODE_MASTER) begin
            n.state   = ST_LOW;
            n.pos     = POS_FIRST;
            n.shf     = s.sbuf[DATA_W-1:0];
            n.tmr     = half;
            n.dout    = out_value(POS_FIRST, md, recv, dir, n.shf, s.sbuf[STOP_BIT]);
          end else if (s.tmr != '0) begin
            n.tmr = s.tmr - HALF_W'(1);
          end else begin
            n.state   = ST_SLAVE;
            n.clk_out = 1'b1;
          end
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase
    // bus start and stop conditions seen on the synchronised pins
    if (md == MODE_SLAVE && start_ev) begin
      run_set   = 1'b1;
      ovr_set   = 1'b1;
      n.state   = ST_SLAVE;
      n.pos     = POS_FIRST;
      n.shf     = s.sbuf[DATA_W-1:0];
      n.clk_out = 1'b1;
      n.dout    = 1'b1;
    end else if (bus_mode && stop_ev) begin
      run_clr   = 1'b1;
      end_set   = 1'b1;
      n.state   = ST_IDLE;
      n.clk_out = 1'b1;
      n.dout    = 1'b1;
    end
    // stray clock fall while not running
    if (!s.ctrl[RUN_BIT] && ((md == MODE_SYNC && ext_clock_select && fall_ev) ||
                             (md == MODE_SLAVE && scl_fall))) begin
      ovr_set = 1'b1;
    end
    // control register; hardware sets win over writes
    n.ctrl = cur;
    if (run_clr && !(ctrl_wr && ctrl_wdata[RUN_BIT])) begin
      n.ctrl[RUN_BIT] = 1'b0;
    end
    if (run_set) begin
      n.ctrl[RUN_BIT] = 1'b1;
    end
    // end arriving while end still set
    if (end_set) begin
      ovr_set         = ovr_set || s.ctrl[END_BIT];
      n.ctrl[END_BIT] = 1'b1;
    end
    if (ovr_set) begin
      n.ctrl[OVR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s         <= '0;
      s.state   <= ST_IDLE;
      s.ctrl    <= CTRL_RESET;
      s.clk_out <= 1'b1;
      s.dout    <= 1'b1;
      s.line_p  <= 1'b1;
      s.scl_p   <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ************************************************************
  // pins and register outputs
  // ************************************************************
  // clock pin drives with the internal clock of mode 0; bus modes only pull it low
  assign shift_clock_pin_out      = bus_mode ? 1'b0 : s.clk_out;
  assign shift_clock_pin_oe_n     = bus_mode ? s.clk_out : !(md == MODE_SYNC && !ext_clock_select);
  assign data_io_pin_out          = bus_mode ? 1'b0 : s.dout;
  assign data_io_pin_oe_n         = bus_mode ? s.dout :
                                    !(dio_tx_route && !s.ctrl[RECV_BIT]);
  assign data_output_pin          = bus_mode ? 1'b1 : s.dout;
  assign serial_control_reg       = s.ctrl;
  assign shift_buffer             = s.sbuf;
  assign processor_status_word_b1 = s.psw1;

endmodule

//--- verif/mmsio_peer.sv
// peer of the clocked mode: shifts a byte onto the data line
// assumes the unit drives the shift clock
`timescale 1ns/1ps
module mmsio_peer import mmsio_pkg::*; #(
  parameter logic [7:0] TX = 8'h3c
) (
  input  wire logic sck,
  input  wire logic sck_oe_n,
  output logic      dio
);
  logic [3:0] n = 4'h0;
  initial dio = 1'b1;
  // next bit msb first on the falling clock
  always @(negedge sck) if (!sck_oe_n) begin
    dio = TX[3'h7 - n[2:0]];
    n = n + 4'h1;
  end
  // released line shows the inverse, not the last bit
  always @(posedge sck) if (n == 4'h8) begin
    dio = ~dio;
    n = 4'h0;
  end
  // async frame, lsb first, two stop bits
  task send_async(input logic [7:0] b, input int bit_ns);
    dio = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      dio = b[i];
      #(bit_ns);
    end
    dio = 1'b1;
    #(2 * bit_ns);
  endtask
endmodule

//--- verif/mmsio_chk_sva.sv
// checker of control, stream and pin behaviour of the serial unit
// assumes a bind onto the unit's ports
`timescale 1ns/1ps
module mmsio_chk import mmsio_pkg::*; (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              ctrl_wr,
  input wire logic [CTRL_W-1:0] ctrl_wdata,
  input wire logic [CTRL_W-1:0] serial_control_reg,
  input wire logic              sbuf_rd,
  input wire logic [SBUF_W-1:0] shift_buffer,
  input wire logic              processor_status_word_b1,
  input wire logic              data_io_pin_out,
  input wire logic              data_output_pin,
  input wire logic              rx_valid,
  input wire logic              rx_ready,
  input wire logic [SBUF_W-1:0] rx_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire [1:0] md = serial_control_reg[7:6];
  a_reset_clear: assert property (
    $rose(rst_n) |-> serial_control_reg == CTRL_RESET) else $error("control not reset");
  a_mode_write: assert property (
    ctrl_wr |=> md == $past(ctrl_wdata[7:6])) else $error("mode bits not written");
  a_status_copy: assert property (
    sbuf_rd |=> processor_status_word_b1 == $past(shift_buffer[STOP_BIT]))
    else $error("stop level not copied");
  a_ovr_sticky: assert property (
    serial_control_reg[OVR_BIT] && !ctrl_wr |=> serial_control_reg[OVR_BIT])
    else $error("overrun cleared by hardware");
  a_end_follows: assert property (
    $fell(serial_control_reg[RUN_BIT]) && md == MODE_SYNC && !$past(ctrl_wr)
    |-> ##[0:2] serial_control_reg[END_BIT]) else $error("end flag missing");
  a_stream_hold: assert property (
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("word lost");
  a_bus_drain: assert property (
    md[1] && $past(md[1]) |-> !data_io_pin_out) else $error("bus data not open drain");
  a_bus_dout: assert property (
    md[1] && $past(md[1]) |-> data_output_pin) else $error("data out not high");
  cover property ($rose(serial_control_reg[END_BIT]));
  cover property ($rose(serial_control_reg[OVR_BIT]));
  cover property (rx_valid && !rx_ready);
endmodule
bind mmsio_serial_unit mmsio_chk mmsio_chk_i (.ref_clk, .rst_n, .ctrl_wr, .ctrl_wdata,
  .serial_control_reg, .sbuf_rd, .shift_buffer, .processor_status_word_b1,
  .data_io_pin_out, .data_output_pin, .rx_valid, .rx_ready, .rx_data);

//--- verif/tb_multimode_serial_io.sv
// bench of the serial unit: clocked transfers, overrun, stall, mode bits
// assumes the peer owns the data line while the unit releases it
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_multimode_serial_io import mmsio_pkg::*;;
  logic              ref_clk = 1'b0, rst_n = 1'b0, link_clk = 1'b0, rx_ready = 1'b0;
  logic              ctrl_wr = 1'b0, sbuf_wr = 1'b0, sbuf_rd = 1'b0;
  logic              ext_clock_select = 1'b0, dio_tx_route = 1'b0;
  logic [CTRL_W-1:0] ctrl_wdata = 8'h00, serial_control_reg;
  logic [SBUF_W-1:0] sbuf_wdata = 9'h000, shift_buffer, rx_data;
  logic [DIV_W-1:0]  baud_divider = 8'h02;
  logic              psw_b1, sck, sck_oe_n, dio, dio_oe_n, dout, rx_valid, peer_dio;
  int                n_errors = 0, compares = 0;
  always #2.5 ref_clk = ~ref_clk;
  // free running link clock keeps the external path moving
  always #16 link_clk = ~link_clk;
  mmsio_serial_unit mmsio_serial_unit_i (.ref_clk, .rst_n, .link_clk, .ctrl_wr, .ctrl_wdata,
    .serial_control_reg, .sbuf_wr, .sbuf_wdata, .sbuf_rd, .shift_buffer,
    .processor_status_word_b1(psw_b1), .baud_divider, .ext_clock_select,
    .dio_tx_route, .shift_clock_pin_in(sck_oe_n ? link_clk : sck),
    .shift_clock_pin_out(sck), .shift_clock_pin_oe_n(sck_oe_n),
    .data_io_pin_in(dio_oe_n ? peer_dio : dio), .data_io_pin_out(dio),
    .data_io_pin_oe_n(dio_oe_n), .data_output_pin(dout), .rx_valid, .rx_ready, .rx_data);
  mmsio_peer mmsio_peer_i (.sck(sck), .sck_oe_n(sck_oe_n), .dio(peer_dio));
  // ********
  // access tasks
  // ********
  // k: 0 control write, 1 buffer write, 2 buffer read
  task acc(input int k, input logic [SBUF_W-1:0] v);
    @(negedge ref_clk);
    ctrl_wr = (k == 0);
    sbuf_wr = (k == 1);
    sbuf_rd = (k == 2);
    ctrl_wdata = v[7:0];
    sbuf_wdata = v;
    @(negedge ref_clk);
    {ctrl_wr, sbuf_wr, sbuf_rd} = 3'h0;
    @(negedge ref_clk);
  endtask
  // bounded wait; running out shows up as a mismatch
  task wait_bit(input int b, input logic lv);
    int i;
    for (i = 0; i < 4000 && serial_control_reg[b] !== lv; i++) @(negedge ref_clk);
    if (i == 4000) `CHK("wait", lv, serial_control_reg[b])
  endtask
  task report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    `CHK("ctrl", CTRL_RESET, serial_control_reg)
    `CHK("dout", 1'b1, dout)
    $display("test reset done");
    acc(1, 9'h1a5);
    acc(0, 9'h028);
    wait_bit(END_BIT, 1'b1);
    `CHK("line byte", 8'h3c, shift_buffer[7:0])
    `CHK("run", 1'b0, serial_control_reg[RUN_BIT])
    `CHK("rx word", 8'h3c, rx_data[7:0])
    acc(2, 9'h000);
    `CHK("psw", 1'b1, psw_b1)
    // second transfer while end still set, receiver stalled
    acc(0, 9'h02a);
    wait_bit(RUN_BIT, 1'b0);
    repeat (4) @(negedge ref_clk);
    `CHK("ovr", 1'b1, serial_control_reg[OVR_BIT])
    `CHK("held", 1'b1, rx_valid)
    rx_ready = 1'b1;
    repeat (4) @(negedge ref_clk);
    `CHK("drained", 1'b0, rx_valid)
    acc(0, 9'h000);
    `CHK("cleared", 8'h00, serial_control_reg)
    $display("test mode 0 done");
    // async send, own bits read back
    dio_tx_route = 1'b1;
    acc(0, 9'h040);
    acc(1, 9'h0c5);
    acc(0, 9'h060);
    wait_bit(END_BIT, 1'b1);
    `CHK("async tx", 9'h1c5, shift_buffer)
    acc(2, 9'h000);
    `CHK("stop psw", 1'b1, psw_b1)
    // peer frames start themselves
    acc(0, 9'h050);
    for (int f = 0; f < 2; f++) begin
      mmsio_peer_i.send_async(8'h96 + f[7:0], 40 * (baud_divider + 1));
      wait_bit(END_BIT, 1'b1);
      `CHK("async rx", {1'b1, 8'h96 + f[7:0]}, shift_buffer)
      acc(0, 9'h050);
    end
    $display("test mode 1 done");
    // ext clock; late fall sets overrun
    ext_clock_select = 1'b1;
    acc(0, 9'h030);
    wait_bit(END_BIT, 1'b1);
    `CHK("ext byte", 8'hff, shift_buffer[7:0])
    repeat (16) @(negedge ref_clk);
    `CHK("stray", 1'b1, serial_control_reg[OVR_BIT])
    $display("test ext done");
    for (int m = 0; m < 4; m++) begin
      acc(0, {1'b0, m[1:0], 6'h00});
      `CHK("mode", m[1:0], serial_control_reg[7:6])
    end
    $display("test modes done");
    report_and_stop();
  end
endmodule
